// File: link_cfg_pkg.sv
// shared constants and types for the link mode and lane parameter block
package link_cfg_pkg;
  // register offsets (register port, byte offsets)
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_KSET = 8'h08;
  localparam logic [7:0] OFS_DEVID = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_INSEL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PARAM0 = 8'h1C;
  localparam logic [7:0] OFS_PARAM1 = 8'h20;
  localparam logic [7:0] OFS_CHKSUM = 8'h24;
  // reset values
  localparam logic [6:0] RST_MODE = 7'h05;
  localparam logic [7:0] RST_KSET = 8'h1F;
  localparam logic [7:0] RST_DEVID = 8'h00;
  // input selector encodings
  localparam logic [1:0] INSEL_FIRST = 2'h0;
  localparam logic [1:0] INSEL_SECOND = 2'h1;
  localparam logic [1:0] INSEL_BOTH = 2'h2;
  // fixed alignment sequence field values
  localparam logic [3:0] JESDV_VAL = 4'h1;
  localparam logic [2:0] SUBCLASSV_VAL = 3'h1;
  localparam logic [7:0] E_VAL = 8'h01;
  localparam logic [8:0] K64_SCALE = 9'h100;
  // R stored in 1/32 units of a bit per clock
  localparam logic [7:0] R_1P03 = 8'h21;
  localparam logic [7:0] R_1P25 = 8'h28;
  localparam logic [7:0] R_2P06 = 8'h42;
  localparam logic [7:0] R_2P5 = 8'h50;
  localparam logic [7:0] R_4P12 = 8'h84;

  typedef struct packed {
    logic valid;
    logic single_ch;
    logic enc64;
    logic [7:0] rate_r;
    logic [1:0] links;
    logic [4:0] lanes_m1;
    logic [7:0] f_m1;
    logic [4:0] m_m1;
    logic [4:0] n_m1;
    logic [4:0] np_m1;
    logic [4:0] s_m1;
    logic [7:0] e_val;
  } mode_params_t;

  typedef struct packed {
    logic [7:0] devid;
    logic [4:0] lanes_m1;
    logic scr;
    logic [7:0] f_m1;
    logic [7:0] k_m1;
    logic [4:0] m_m1;
    logic [4:0] n_m1;
    logic [4:0] np_m1;
    logic [4:0] s_m1;
  } ilas_fields_t;
endpackage

// File: link_mode_params.sv
// link mode decode, lane parameter derivation and alignment checksum
//
// Summary of operation
// - single-channel mode samples at twice clock
// - dual-input mode: single-channel mode, both inputs
// - dual-input mode links like single-channel
// - interleave flag derived from link mode
// - bits per lane per clock derived
// - one mode selector sets all parameters except 8b/10b K, device identifier and scrambler
// - K from register only in 8b/10b
// - E fixed at 1 in 64b/66b
// - ILAS in 8b/10b only, same parameters
// - adjust, bank, control, reserved fields zero
// - control bits field reported zero
// - high-density field reported zero
// - device identifier from user register
// - scrambler field follows control register
// - converter count is packing value
// - N and N' reported separately
// - checksum is field sum modulo 256
// - 64b/66b K equals 256 times E over F
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module link_mode_params
  import link_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic serial_link_enable,
  output logic interleave_en,
  output logic enc64_active,
  output logic ilas_send_en,
  output logic dual_input_en,
  output logic [1:0] adc_input_route,
  output logic [7:0] lane_rate_r,
  output logic [4:0] lanes_active_m1,
  output logic [7:0] frame_octets_m1,
  output logic [8:0] multiframe_frames,
  output logic [7:0] ilas_chksum,
  output logic cal_pending
);

  //////////////////////////////////////////////////////////////////////////
  // decode of one link mode into its transport parameters
  function automatic mode_params_t decode_mode(input logic [6:0] md);
    mode_params_t p;
    p = '0;
    p.links = 2'h2;
    p.f_m1 = 8'h00;
    p.m_m1 = 5'h00;
    p.n_m1 = 5'h07;
    p.np_m1 = 5'h07;
    // single-channel modes interleave both converters
    case (md)
      7'h05: begin
        p.valid = 1'b1;
        p.single_ch = 1'b1;
        p.lanes_m1 = 5'h03;
        p.rate_r = R_2P5;
      end
      7'h07: begin
        p.valid = 1'b1;
        p.lanes_m1 = 5'h03;
        p.rate_r = R_2P5;
      end
      7'h06: begin
        p.valid = 1'b1;
        p.single_ch = 1'b1;
        p.lanes_m1 = 5'h07;
        p.rate_r = R_1P25;
      end
      7'h08: begin
        p.valid = 1'b1;
        p.lanes_m1 = 5'h07;
        p.rate_r = R_1P25;
      end
      7'h22: begin
        p.valid = 1'b1;
        p.single_ch = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h01;
        p.rate_r = R_4P12;
      end
      7'h23: begin
        p.valid = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h01;
        p.rate_r = R_4P12;
      end
      7'h2C: begin
        p.valid = 1'b1;
        p.single_ch = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h03;
        p.rate_r = R_2P06;
      end
      7'h2D: begin
        p.valid = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h03;
        p.rate_r = R_2P06;
      end
      7'h32: begin
        p.valid = 1'b1;
        p.single_ch = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h07;
        p.rate_r = R_1P03;
      end
      7'h33: begin
        p.valid = 1'b1;
        p.enc64 = 1'b1;
        p.lanes_m1 = 5'h07;
        p.rate_r = R_1P03;
      end
      default: begin
        p.valid = 1'b0;
      end
    endcase
    p.s_m1 = p.lanes_m1; // S equals lanes per link in every mode
    p.e_val = p.enc64 ? E_VAL : 8'h00;
    return p;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // checksum over the alignment fields, each field as transmitted
  function automatic logic [7:0] ilas_sum(input ilas_fields_t f);
    logic [11:0] s;
    s = 12'h000;
    s = s + {4'h0, f.devid};
    // adjust count, bank id, adjust direction, lane id, cf, cs, hd,
    // reserved fields all contribute zero
    s = s + {7'h00, f.lanes_m1};
    s = s + {11'h000, f.scr};
    s = s + {4'h0, f.f_m1};
    s = s + {4'h0, f.k_m1};
    s = s + {7'h00, f.m_m1};
    s = s + {7'h00, f.n_m1};
    s = s + {7'h00, f.np_m1};
    s = s + {9'h000, SUBCLASSV_VAL};
    s = s + {8'h00, JESDV_VAL};
    s = s + {7'h00, f.s_m1};
    return s[7:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic enable_r;
  logic [6:0] mode_r;
  logic [7:0] kset_r;
  logic [7:0] devid_r;
  logic scr_r;
  logic [1:0] insel_r;
  logic cal_pend_r;
  logic [31:0] rdata_r;

  wire wr_enable = reg_wr && reg_addr == OFS_ENABLE;
  wire link_off = !enable_r;
  // parameter writes except the input selector only land while the link is held off
  wire wr_mode = reg_wr && reg_addr == OFS_MODE && link_off;
  wire wr_kset = reg_wr && reg_addr == OFS_KSET && link_off;
  wire wr_devid = reg_wr && reg_addr == OFS_DEVID && link_off;
  wire wr_ctrl = reg_wr && reg_addr == OFS_CTRL && link_off;
  wire wr_insel = reg_wr && reg_addr == OFS_INSEL;
  // bit 0 of status written as 1 acknowledges a calibration
  wire wr_calack = reg_wr && reg_addr == OFS_STATUS && reg_wdata[0];
  // selector code 3 is not a legal route and is dropped
  wire insel_ok = wr_insel && reg_wdata[1:0] != 2'h3;
  wire insel_change = insel_ok && reg_wdata[1:0] != insel_r;

  // next values; each register except cal_pend_r holds unless its own write lands
  wire enable_nxt = wr_enable ? reg_wdata[0] : enable_r;
  wire [6:0] mode_nxt = wr_mode ? reg_wdata[6:0] : mode_r;
  wire [7:0] kset_nxt = wr_kset ? reg_wdata[7:0] : kset_r;
  wire [7:0] devid_nxt = wr_devid ? reg_wdata[7:0] : devid_r;
  wire scr_nxt = wr_ctrl ? reg_wdata[0] : scr_r;
  wire [1:0] insel_nxt = insel_ok ? reg_wdata[1:0] : insel_r;
  // a new selection sets pending; set wins over acknowledge
  wire cal_pend_nxt = insel_change || (cal_pend_r && !wr_calack);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_r <= 1'b0;
    end else if (clk_en) begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= RST_MODE;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kset_r <= RST_KSET;
    end else if (clk_en) begin
      kset_r <= kset_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      devid_r <= RST_DEVID;
    end else if (clk_en) begin
      devid_r <= devid_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scr_r <= 1'b0;
    end else if (clk_en) begin
      scr_r <= scr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      insel_r <= INSEL_FIRST;
    end else if (clk_en) begin
      insel_r <= insel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_pend_r <= 1'b0;
    end else if (clk_en) begin
      cal_pend_r <= cal_pend_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // derived parameters
  mode_params_t mp;
  ilas_fields_t fld;
  logic [7:0] k_m1_eff;
  logic [8:0] k64;
  logic [7:0] chk;

  assign mp = decode_mode(mode_r);
  // 64b/66b: K = 8*32*E/F; F is 1 here so K is 256*E
  assign k64 = 9'((K64_SCALE * 9'(mp.e_val)) / (9'(mp.f_m1) + 9'h001));
  assign k_m1_eff = mp.enc64 ? 8'(k64 - 9'h001) : kset_r;
  assign fld.devid = devid_r;
  assign fld.lanes_m1 = mp.lanes_m1;
  assign fld.scr = scr_r;
  assign fld.f_m1 = mp.f_m1;
  assign fld.k_m1 = k_m1_eff;
  assign fld.m_m1 = mp.m_m1;
  assign fld.n_m1 = mp.n_m1;
  assign fld.np_m1 = mp.np_m1;
  assign fld.s_m1 = mp.s_m1;
  assign chk = ilas_sum(fld);

  wire dual_in = mp.single_ch && insel_r == INSEL_BOTH;

  assign serial_link_enable = enable_r && mp.valid;
  assign interleave_en = mp.single_ch;
  assign enc64_active = mp.enc64;
  assign ilas_send_en = serial_link_enable && !mp.enc64;
  assign dual_input_en = dual_in;
  // dual-input only changes the analog routing, not the link path
  assign adc_input_route = insel_r;
  assign lane_rate_r = mp.rate_r;
  assign lanes_active_m1 = mp.lanes_m1;
  assign frame_octets_m1 = mp.f_m1;
  assign multiframe_frames = mp.enc64 ? k64 : 9'(kset_r) + 9'h001;
  assign ilas_chksum = chk;
  assign cal_pending = cal_pend_r;

  //////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      OFS_ENABLE: rd_mux = {31'h0, enable_r};
      OFS_MODE: rd_mux = {25'h0, mode_r};
      OFS_KSET: rd_mux = {24'h0, kset_r};
      OFS_DEVID: rd_mux = {24'h0, devid_r};
      OFS_CTRL: rd_mux = {31'h0, scr_r};
      OFS_INSEL: rd_mux = {30'h0, insel_r};
      OFS_STATUS: rd_mux = {27'h0, mp.enc64, dual_in, mp.single_ch,
                            mp.valid, cal_pend_r};
      OFS_PARAM0: rd_mux = {mp.rate_r, 3'h0, mp.lanes_m1, mp.f_m1,
                            k_m1_eff};
      // only the low nibble of E fits; E never exceeds 1
      OFS_PARAM1: rd_mux = {mp.e_val[3:0], 1'b0, mp.m_m1, 1'b0, mp.n_m1,
                            3'h0, mp.np_m1, mp.links, 1'b0, mp.s_m1};
      OFS_CHKSUM: rd_mux = {24'h0, chk};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire

// File: link_mode_checker.sv
// port checker for the link mode and lane parameter block
`timescale 1ns/1ps
`default_nettype none
module link_mode_checker
  import link_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic serial_link_enable,
  input wire logic interleave_en,
  input wire logic enc64_active,
  input wire logic ilas_send_en,
  input wire logic dual_input_en,
  input wire logic [1:0] adc_input_route,
  input wire logic [7:0] lane_rate_r,
  input wire logic [4:0] lanes_active_m1,
  input wire logic [7:0] frame_octets_m1,
  input wire logic [8:0] multiframe_frames
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire live = lane_rate_r != 8'h00;
  ilas_enc_a: assert property (
    ilas_send_en == (serial_link_enable && !enc64_active))
    else $error("alignment send flag wrong");
  k_wide_a: assert property (
    enc64_active |-> multiframe_frames == 9'h100)
    else $error("64b multiframe length wrong");
  dual_in_a: assert property (
    dual_input_en == (interleave_en && adc_input_route == INSEL_BOTH))
    else $error("dual input flag wrong");
  rdata_idle_a: assert property (
    clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  dead_mode_a: assert property (
    !live |-> !serial_link_enable && !interleave_en)
    else $error("invalid mode drives link");
  lane_total_a: assert property (
    live |-> lane_rate_r * (lanes_active_m1 + 1) == (enc64_active ? 264 : 320))
    else $error("lane rate and count disagree");
  frame_size_a: assert property (
    live |-> frame_octets_m1 == 8'h00)
    else $error("frame size wrong");
  mode_hold_a: assert property (
    clk_en && reg_wr && reg_addr == OFS_MODE && serial_link_enable
    |=> $stable(lane_rate_r) && $stable(interleave_en))
    else $error("mode changed while link enabled");
  cover property (dual_input_en);
  cover property (ilas_send_en);
  cover property (enc64_active && serial_link_enable);
endmodule
bind link_mode_params link_mode_checker link_mode_checker_i (.clk(clk),
  .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_link_enable(serial_link_enable), .interleave_en(interleave_en),
  .enc64_active(enc64_active), .ilas_send_en(ilas_send_en),
  .dual_input_en(dual_input_en), .adc_input_route(adc_input_route),
  .lane_rate_r(lane_rate_r), .lanes_active_m1(lanes_active_m1),
  .frame_octets_m1(frame_octets_m1),
  .multiframe_frames(multiframe_frames));
`default_nettype wire

// File: rx_model.sv
// receiver model: locks a while after link enable, keeps alignment checksum
`timescale 1ns/1ps
`default_nettype none
module rx_model #(
  parameter int LAT = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_en,
  input wire logic ilas_en,
  input wire logic [7:0] chksum,
  output logic locked,
  output logic [7:0] seen_chksum
);
  int cnt;
  always @(posedge clk) begin
    if (!rst_n || !link_en) begin
      cnt <= 0;
      locked <= 1'b0;
    end else if (cnt < LAT) begin
      cnt <= cnt + 1;
    end else begin
      locked <= 1'b1;
    end
    if (rst_n && link_en && ilas_en && cnt == 0) begin
      seen_chksum <= chksum;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the link mode block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import link_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic serial_link_enable, interleave_en, enc64_active, ilas_send_en;
  logic dual_input_en, cal_pending, locked;
  logic [1:0] adc_input_route;
  logic [7:0] lane_rate_r, frame_octets_m1, ilas_chksum, seen;
  logic [4:0] lanes_active_m1;
  logic [8:0] multiframe_frames;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] seed = 8'h58;
  always #12.5 clk = ~clk;
  link_mode_params link_mode_params_i (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_link_enable(serial_link_enable), .interleave_en(interleave_en),
    .enc64_active(enc64_active), .ilas_send_en(ilas_send_en),
    .dual_input_en(dual_input_en), .adc_input_route(adc_input_route),
    .lane_rate_r(lane_rate_r), .lanes_active_m1(lanes_active_m1),
    .frame_octets_m1(frame_octets_m1),
    .multiframe_frames(multiframe_frames), .ilas_chksum(ilas_chksum),
    .cal_pending(cal_pending));
  rx_model #(.LAT(4)) rx_model_i (.clk(clk), .rst_n(rst_n),
    .link_en(serial_link_enable), .ilas_en(ilas_send_en),
    .chksum(ilas_chksum), .locked(locked), .seen_chksum(seen));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // {single, enc64, rate, lanes-1} per mode
  function automatic logic [14:0] mode_ref(input logic [6:0] m);
    case (m)
      7'h05: return {2'h2, R_2P5, 5'h03};
      7'h06: return {2'h2, R_1P25, 5'h07};
      7'h07: return {2'h0, R_2P5, 5'h03};
      7'h08: return {2'h0, R_1P25, 5'h07};
      7'h22: return {2'h3, R_4P12, 5'h01};
      7'h23: return {2'h1, R_4P12, 5'h01};
      7'h2C: return {2'h3, R_2P06, 5'h03};
      7'h2D: return {2'h1, R_2P06, 5'h03};
      7'h32: return {2'h3, R_1P03, 5'h07};
      7'h33: return {2'h1, R_1P03, 5'h07};
      default: return 15'h0000;
    endcase
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] k, dv, r;
    logic [1:0] ins;
    logic sg, e6, scr;
    logic [4:0] l;
    logic [31:0] d;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_MODE, d);
    cmp(d, 32'(RST_MODE));
    rd(OFS_KSET, d);
    cmp(d, 32'(RST_KSET));
    rd(OFS_DEVID, d);
    cmp(d, 32'(RST_DEVID));
    rd(8'hFC, d);
    cmp(d, 32'h0);
    for (int i = 0; i < 128; i++) begin
      seed = lfsr(seed);
      k = seed;
      dv = ~seed;
      scr = seed[3];
      ins = 2'(seed % 3);
      wr(OFS_MODE, 32'(i));
      wr(OFS_KSET, 32'(k));
      wr(OFS_DEVID, 32'(dv));
      wr(OFS_CTRL, 32'(scr));
      wr(OFS_INSEL, 32'(ins));
      @(negedge clk);
      {sg, e6, r, l} = mode_ref(7'(i));
      cmp(lane_rate_r, r);
      cmp(interleave_en, sg);
      cmp(dual_input_en, sg && ins == INSEL_BOTH);
      cmp(adc_input_route, ins);
      if (r != 8'h00) begin
        cmp(enc64_active, e6);
        cmp(lanes_active_m1, l);
        cmp(frame_octets_m1, 8'h00);
        cmp(multiframe_frames, e6 ? 9'h100 : 9'(k) + 9'h001);
        if (!e6) begin
          cmp(ilas_chksum, 8'(dv + k + scr + 2 * l + 16));
        end
      end
      @(posedge clk);
    end
    wr(OFS_MODE, 32'h05);
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_MODE, 32'h07);
    repeat (8) @(posedge clk);
    @(negedge clk);
    cmp(interleave_en, 1'b1);
    cmp(ilas_send_en, 1'b1);
    cmp(locked, 1'b1);
    cmp(seen, 8'(dv + k + scr + 22));
    @(posedge clk);
    rd(OFS_CHKSUM, d);
    cmp(d, 32'(8'(dv + k + scr + 22)));
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_MODE, 32'h22);
    wr(OFS_ENABLE, 32'h1);
    @(negedge clk);
    cmp(serial_link_enable && !ilas_send_en, 1'b1);
    @(posedge clk);
    rd(OFS_PARAM0, d);
    cmp(d, 32'h8401_00FF);
    rd(OFS_PARAM1, d);
    cmp(d, 32'h1007_0781);
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_INSEL, 32'(ins == 2'h0 ? 2'h1 : 2'h0));
    @(negedge clk);
    cmp(cal_pending, 1'b1);
    @(posedge clk);
    rd(OFS_STATUS, d);
    cmp(d, 32'h0000_0017);
    wr(OFS_STATUS, 32'h1);
    @(negedge clk);
    cmp(cal_pending, 1'b0);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(OFS_DEVID, 32'(~dv));
    clk_en <= 1'b1;
    rd(OFS_DEVID, d);
    cmp(d, 32'(dv));
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
